// ---- logic/pbda_pkg.sv ----
// Purpose: Shared constants for the packed decimal adjust slice.
// Assumes: One core clock edge per quarter cycle of an instruction.
// Notes:   Phase codes are one-hot, one bit per quarter cycle.
package pbda_pkg;

    localparam int        PBDA_DATA_W   = 8;          // Accumulator width.
    localparam int        PBDA_NIB_W    = 4;          // Width of one packed digit.
    localparam logic [3:0] PBDA_NIB_MAX = 4'h9;       // Largest legal decimal digit.
    localparam logic [3:0] PBDA_NIB_FIX = 4'h6;       // Correction added to a digit.
    localparam logic       PBDA_CARRY_SET = 1'h1;     // Value written to carry on a fix.

    // Quarter cycles of one instruction cycle.
    typedef enum logic [3:0] {
        PBDA_Q1 = 4'h1,
        PBDA_Q2 = 4'h2,
        PBDA_Q3 = 4'h4,
        PBDA_Q4 = 4'h8
    } pbda_phase_type;

    localparam pbda_phase_type PBDA_PHASE_RST = PBDA_Q1;

endpackage

// ---- logic/pbda_nibble_fix.sv ----
// Purpose: Corrects one packed decimal digit.
// Assumes: Purely combinational; the caller registers the result.
// Notes:   The sum keeps only four bits, so any carry out of the digit is dropped.
`timescale 1ns/10ps
module pbda_nibble_fix
    import pbda_pkg::*;
(
    input  wire logic [PBDA_NIB_W-1:0] nib,
    input  wire logic                  force_fix,
    output wire logic [PBDA_NIB_W-1:0] res,
    output wire logic                  fixed
);

    // A digit above nine or a pending carry into it calls for the correction.
    assign fixed = (nib > PBDA_NIB_MAX) || force_fix;
    assign res   = fixed ? PBDA_NIB_W'(nib + PBDA_NIB_FIX) : nib;

endmodule

// ---- logic/pbda_adjust.sv ----
// Purpose: Decimal adjust of the accumulator after a packed BCD addition.
// Assumes: The core issues bcd_fixup_op in the first quarter cycle and owns the flags.
// Notes:   One instruction cycle is four clock edges tracked by phase_q.
//
// Functional notes
// - Low digit above nine or flag: add six.
// - Otherwise low digit is written back unchanged.
// - High digit above nine or carry: add six.
// - High fix sets carry; no other flag changes.
`timescale 1ns/10ps
module pbda_adjust
    import pbda_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    input  wire logic                   bcd_fixup_op,
    input  wire logic [PBDA_DATA_W-1:0] acc_in,
    input  wire logic                   half_byte_wrap_flag,
    input  wire logic                   carry_in,
    output logic      [3:0]             phase_q,
    output logic      [PBDA_DATA_W-1:0] acc_out_q,
    output logic                        acc_we_q,
    output logic                        carry_out_q,
    output logic                        carry_we_q
);

    pbda_phase_type             phase_cur_q;
    pbda_phase_type             phase_nxt_d;
    logic                       run_q;
    logic [PBDA_DATA_W-1:0]     acc_hold_q;
    logic                       dc_hold_q;
    logic                       c_hold_q;
    wire logic [PBDA_NIB_W-1:0] lo_res;
    wire logic [PBDA_NIB_W-1:0] hi_res;
    wire logic                  lo_fixed;
    wire logic                  hi_fixed;
    wire logic                  in_q1;
    wire logic                  in_q2;
    wire logic                  in_q3;

    // Phase decode and successor; an unknown code falls back to Q1.
    assign in_q1 = (phase_cur_q == PBDA_Q1);
    assign in_q2 = (phase_cur_q == PBDA_Q2);
    assign in_q3 = (phase_cur_q == PBDA_Q3);

    always_comb begin
        case (phase_cur_q)
            PBDA_Q1: phase_nxt_d = PBDA_Q2;
            PBDA_Q2: phase_nxt_d = PBDA_Q3;
            PBDA_Q3: phase_nxt_d = PBDA_Q4;
            PBDA_Q4: phase_nxt_d = PBDA_Q1;
            default: phase_nxt_d = PBDA_PHASE_RST;
        endcase
    end

    // Quarter cycle counter, visible to the core so it can align its issue.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_cur_q <= PBDA_PHASE_RST;
            phase_q     <= PBDA_PHASE_RST;
        end else begin
            phase_cur_q <= phase_nxt_d;
            phase_q     <= phase_nxt_d;
        end
    end

    // Issue is only honoured in Q1 so a stray pulse mid-cycle cannot start a second pass.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            run_q <= 1'b0;
        end else if (in_q1) begin
            run_q <= bcd_fixup_op;
        end
    end

    // Operands are sampled in Q2 only, so the core may change them freely elsewhere.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_hold_q <= '0;
            dc_hold_q  <= 1'b0;
            c_hold_q   <= 1'b0;
        end else if (in_q2 && run_q) begin
            acc_hold_q <= acc_in;
            dc_hold_q  <= half_byte_wrap_flag;
            c_hold_q   <= carry_in;
        end
    end

    // Each digit is corrected on its own; no carry passes from the low to the high digit.
    pbda_nibble_fix u_lo (
        .nib       (acc_hold_q[PBDA_NIB_W-1:0]),
        .force_fix (dc_hold_q),
        .res       (lo_res),
        .fixed     (lo_fixed)
    );

    pbda_nibble_fix u_hi (
        .nib       (acc_hold_q[PBDA_DATA_W-1:PBDA_NIB_W]),
        .force_fix (c_hold_q),
        .res       (hi_res),
        .fixed     (hi_fixed)
    );

    // Results are registered at the end of Q3 so the write strobes stand for all of Q4.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_out_q   <= '0;
            acc_we_q    <= 1'b0;
            carry_out_q <= 1'b0;
            carry_we_q  <= 1'b0;
        end else begin
            acc_we_q   <= in_q3 && run_q;
            carry_we_q <= in_q3 && run_q && hi_fixed;
            if (in_q3 && run_q) begin
                acc_out_q   <= {hi_res, lo_res};
                carry_out_q <= hi_fixed ? PBDA_CARRY_SET : c_hold_q;
            end
        end
    end

    // Checks on the outputs against the operands held in Q2.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_issue;
        in_q1 && bcd_fixup_op;
    endsequence

    sequence s_write;
        ##3 acc_we_q ##1 !acc_we_q;
    endsequence

    a_issue_to_write: assert property (s_issue |-> s_write)
        else $error("Adjust write not in Q4 of issuing cycle.");

    a_no_spurious_write: assert property (acc_we_q |-> $past(in_q3) && $past(run_q))
        else $error("Accumulator write outside an adjust.");

    a_low_fix: assert property (acc_we_q && (acc_hold_q[3:0] > PBDA_NIB_MAX || dc_hold_q)
        |-> acc_out_q[3:0] == 4'(acc_hold_q[3:0] + PBDA_NIB_FIX))
        else $error("Low digit not corrected.");

    a_low_keep: assert property (acc_we_q && acc_hold_q[3:0] <= PBDA_NIB_MAX && !dc_hold_q
        |-> acc_out_q[3:0] == acc_hold_q[3:0])
        else $error("Low digit changed without cause.");

    a_high_digit: assert property (acc_we_q |-> acc_out_q[7:4] ==
        ((acc_hold_q[7:4] > PBDA_NIB_MAX || c_hold_q) ?
         4'(acc_hold_q[7:4] + PBDA_NIB_FIX) : acc_hold_q[7:4]))
        else $error("High digit wrong.");

    a_carry_set: assert property (acc_we_q && (acc_hold_q[7:4] > PBDA_NIB_MAX)
        |-> carry_we_q && carry_out_q)
        else $error("Carry not set on high correction.");

    a_carry_quiet: assert property (carry_we_q |-> acc_we_q && carry_out_q)
        else $error("Carry written without high correction.");

    // A set carry forces the high correction even for a legal high digit.
    // Without this check a design that ignored the carry input would still pass
    // the carry test above whenever the bench kept the high digit legal.
    a_carry_from_flag: assert property (acc_we_q && c_hold_q |-> carry_we_q && carry_out_q)
        else $error("Carry not set when carry flag forced high correction.");

    // With no high correction the carry keeps its old value and is not written.
    a_carry_keep: assert property (acc_we_q && !(acc_hold_q[7:4] > PBDA_NIB_MAX) && !c_hold_q
        |-> !carry_we_q && carry_out_q == c_hold_q)
        else $error("Carry changed without high correction.");

    // The quarter counter is one-hot and steps Q1, Q2, Q3, Q4 and back to Q1.
    // The core aligns its issue to this counter, so a skipped or doubled phase
    // would shift the operand sample and the write-back by a whole quarter.
    sequence s_at_q4;
        phase_q == PBDA_Q4;
    endsequence

    sequence s_mid_cycle;
        phase_q != PBDA_Q4;
    endsequence

    a_phase_onehot: assert property ($onehot(phase_q))
        else $error("Quarter phase is not one-hot.");

    a_phase_wrap: assert property (s_at_q4 |=> phase_q == PBDA_Q1)
        else $error("Quarter phase did not wrap from Q4 to Q1.");

    a_phase_step: assert property (s_mid_cycle |=> phase_q == {$past(phase_q[2:0]), 1'b0})
        else $error("Quarter phase did not advance by one.");

    // The write strobes may only stand in the fourth quarter of a cycle.
    a_strobe_in_q4: assert property (acc_we_q || carry_we_q |-> s_at_q4)
        else $error("Write strobe outside Q4.");

    // The results are held between write-backs; a change without a write
    // would hand the core a value it never asked for.
    a_acc_hold: assert property ($changed(acc_out_q) |-> acc_we_q)
        else $error("Accumulator result changed without a write.");

    a_carry_hold: assert property ($changed(carry_out_q) |-> acc_we_q)
        else $error("Carry result changed without a write.");

endmodule

// ---- sim/pbda_core_model.sv ----
// Purpose: Core side of the adjust slice: issues the op and presents the flags.
// Assumes: The bench changes req and the values only on the falling edge.
// Notes:   Values are shown only in Q2, so a late or early sample reads wrong data.
`timescale 1ns/10ps
module pbda_core_model
    import pbda_pkg::*;
(
    input  wire logic [3:0] phase_q,
    input  wire logic       req,
    input  wire logic [7:0] acc_val,
    input  wire logic [1:0] flags_val,
    output wire logic       bcd_fixup_op,
    output wire logic [7:0] acc_in,
    output wire logic       half_byte_wrap_flag,
    output wire logic       carry_in
);
    wire logic in_q2 = (phase_q == PBDA_Q2);

    // Outside Q2 the inverse is driven so that a stale sample cannot match.
    assign bcd_fixup_op        = req && (phase_q == PBDA_Q1);
    assign acc_in              = in_q2 ? acc_val : ~acc_val;
    assign half_byte_wrap_flag = in_q2 ? flags_val[1] : ~flags_val[1];
    assign carry_in            = in_q2 ? flags_val[0] : ~flags_val[0];
endmodule

// ---- sim/tb.sv ----
// Purpose: Self-checking bench for the decimal adjust slice.
// Assumes: Inputs change on the falling edge of a 40 ns clock.
// Notes:   Expected digits are worked out here, apart from the design.
`timescale 1ns/10ps
module tb
    import pbda_pkg::*;
;
    logic       clk = 1'h0;
    logic       arst_n = 1'h0;
    logic       req = 1'h0;
    logic [7:0] acc_val = 8'h00;
    logic [1:0] flg = 2'h0;
    logic       op, dcf, cf, awe, cwe, cout;
    logic [7:0] ain, aout;
    logic [3:0] ph;
    int         fail_count = 0;
    int         checked = 0;

    pbda_core_model core (.phase_q(ph), .req(req), .acc_val(acc_val), .flags_val(flg),
        .bcd_fixup_op(op), .acc_in(ain), .half_byte_wrap_flag(dcf), .carry_in(cf));
    pbda_adjust dut (.clk(clk), .arst_n(arst_n), .bcd_fixup_op(op), .acc_in(ain),
        .half_byte_wrap_flag(dcf), .carry_in(cf), .phase_q(ph), .acc_out_q(aout),
        .acc_we_q(awe), .carry_out_q(cout), .carry_we_q(cwe));

    // Free-running core clock.
    initial forever #20 clk = ~clk;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Issues one op in the next Q1 and judges the write-back in Q4.
    task automatic run_op(input logic [7:0] a, input logic [1:0] f);
        logic       lf, hf;
        logic [7:0] e;
        int         n;
        lf = (a[3:0] > 4'h9) || f[1];
        hf = (a[7:4] > 4'h9) || f[0];
        e = {a[7:4] + (hf ? 4'h6 : 4'h0), a[3:0] + (lf ? 4'h6 : 4'h0)};
        n = 0;
        while (ph !== 4'h1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        if (ph !== 4'h1) begin
            check({4'h0, ph}, 8'h01);
            close_out();
        end
        req = 1'h1;
        acc_val = a;
        flg = f;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (awe !== 1'h1 && n < 8);
        check(8'(n), 8'h03);
        check({4'h0, ph}, 8'h08);
        check(aout, e);
        check({7'h0, cwe}, {7'h0, hf});
        check({7'h0, cout}, {7'h0, hf | f[0]});
        if (n >= 8) close_out();
    endtask

    // Back-to-back issues over digit boundaries and every flag mix.
    task automatic sc_table();
        logic [7:0] av [10] = '{8'hA5, 8'hCE, 8'h99, 8'h9A, 8'hA9,
                                8'h00, 8'h00, 8'h00, 8'hFF, 8'h66};
        logic [1:0] fv [10] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h1, 2'h3, 2'h3, 2'h0};
        for (int i = 0; i < 10; i++) begin
            run_op(av[i], fv[i]);
        end
        req = 1'h0;
    endtask

    // With no issue, a whole instruction cycle passes without a write strobe.
    task automatic sc_idle();
        repeat (5) begin
            @(negedge clk);
            check({6'h0, awe, cwe}, 8'h00);
        end
    endtask

    initial begin
        repeat (16) @(negedge clk);
        arst_n = 1'h1;
        // Let the first edge move the counter to Q2, so the first issue lands in a full cycle.
        @(negedge clk);
        sc_table();
        sc_idle();
        close_out();
    end
endmodule
